/* File: rtl/cdmp_channel.sv */
// per-channel dma handshake and modem pin logic with ahb-lite registers
`timescale 1ns/1ps
// Function
// - with cts gating on and no loop mode, transmitter sends only while cts asserted
// - cts level changes outside loop mode are flagged and raise an interrupt when enabled
// - in bit-oriented loop mode the cts pin drives loop control set by software
// - carrier input gates the receiver or reads as a general input
// - carrier level changes outside external sync mode are flagged and raise an interrupt when enabled
// - carrier as external sync in character mode forces receiver sync on assertion
// - half-duplex request asserts for receive data or transmit space of enabled side
// - full-duplex combined request serves only receive data available
// - outside dma the combined request pin is a software output
// - full-duplex transmit request asserts while transmit fifo not full
// - otherwise transmit request pin is software general output or request-to-send
// - half-duplex acknowledge reads receive fifo or loads transmit fifo by direction
// - full-duplex combined acknowledge reads the receive fifo that cycle
// - full-duplex transmit acknowledge loads the transmit fifo that cycle
// - acknowledge pins read as general inputs when not in that dma mode
// - end-of-process pin works in both dma and non-dma operation
// - end-of-process input during a transmit load marks the last transfer
// - end-of-process driven low on last receive read or transmit terminal count
// - sync-detect output asserts one bit time after sync or flag detection
// - ready asserts on strobe leading edge in wait mode if fifo cannot serve
module cdmp_channel import cdmp_pkg::*; (
  input wire logic hclk, // 100 MHz system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [CDMP_ADDR_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write transfer
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [CDMP_DATA_W-1:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [CDMP_DATA_W-1:0] hrdata, // read data
  input wire logic clear_to_send_in_n, // cts pin input level
  output logic loop_control_out_n, // loop control drive level
  output logic loop_control_oe, // cts pin driven as loop control
  input wire logic carrier_detect_in_n, // carrier or external sync pin
  output logic combined_dma_request_n, // combined request or general output one
  output logic transmit_dma_request_n, // transmit request, output two or rts
  output logic sync_detect_out_n, // sync detect or second rts
  input wire logic combined_dma_acknowledge_n, // combined acknowledge or input one
  input wire logic transmit_dma_acknowledge_n, // transmit acknowledge or input two
  input wire logic end_of_process_in_n, // end-of-process wire level
  output logic end_of_process_out_n, // end-of-process drive level, always low
  output logic end_of_process_oe, // end-of-process pulled low
  output logic ready_wait_out_n, // ready drive level, always low
  output logic ready_wait_oe, // ready pulled low
  input wire logic rx_enabled, // receiver enabled
  input wire logic tx_enabled, // transmitter enabled
  input wire logic rx_fifo_not_empty, // receive fifo holds a character
  input wire logic rx_fifo_last, // receive fifo holds exactly one character
  input wire logic tx_fifo_not_full, // transmit fifo has space
  input wire logic tx_count_terminal, // pulse: transmit count reached terminal
  input wire logic rx_sync_found, // pulse: sync character or flag found
  input wire logic bit_tick, // one-cycle pulse per bit time
  input wire logic read_strobe, // cpu read strobe level, active high
  input wire logic write_strobe, // cpu write strobe level, active high
  output logic tx_allow, // transmitter may send
  output logic rx_allow, // receiver may run
  output logic rx_sync_force, // pulse: take character sync now
  output logic dma_rx_read, // pulse: read receive fifo for dma
  output logic dma_tx_load, // pulse: load transmit fifo from dma
  output logic dma_tx_last, // pulse: that load was the last one
  output logic modem_irq // transition interrupt request level
);
  logic [CDMP_MODE_W-1:0] mode;
  logic [CDMP_OUTS_W-1:0] outs;
  logic [CDMP_EVT_W-1:0] events;
  logic [CDMP_IEN_W-1:0] irq_en;
  logic ph_write;
  logic [CDMP_ADDR_W-1:0] ph_addr;
  logic [1:0] ack_prev;
  logic rd_prev;
  logic wr_prev;
  cdmp_sync_type sy_state;
  cdmp_sync_type next_sy_state;
  logic [1:0] pin_level;
  logic [1:0] pin_change;
  wire [1:0] dma_mode = mode[CDMP_M_DMA +: 2];
  wire in_half = dma_mode == CDMP_DMA_HALF;
  wire in_full = dma_mode == CDMP_DMA_FULL;
  wire in_dma = dma_mode != CDMP_DMA_NONE;
  wire single_addr = mode[CDMP_M_SINGLE];
  wire loop_mode = mode[CDMP_M_LOOP];
  wire ext_sync = mode[CDMP_M_EXT_SYNC];
  wire cts_level = pin_level[0];
  wire dcd_level = pin_level[1];
  wire ack1_level = ~combined_dma_acknowledge_n;
  wire ack2_level = ~transmit_dma_acknowledge_n;
  wire eop_in_level = ~end_of_process_in_n;

  // cts changes are only meaningful while the pin is an input
  wire [1:0] watch = {~ext_sync, ~loop_mode};

  cdmp_pin_watch #(
    .WIDTH(2)
  ) u_watch (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins_n({carrier_detect_in_n, clear_to_send_in_n}),
    .watch(watch),
    .level(pin_level),
    .change(pin_change)
  );

  // bus decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire wr_now = ph_write;
  wire hit_mode = ph_addr == CDMP_MODE_ADDR;
  wire hit_outs = ph_addr == CDMP_OUTS_ADDR;
  wire hit_evt = ph_addr == CDMP_EVT_ADDR;
  wire hit_ien = ph_addr == CDMP_IEN_ADDR;
  wire [CDMP_STAT_W-1:0] status = {tx_fifo_not_full, rx_fifo_not_empty, eop_in_level,
                                   ack2_level, ack1_level, dcd_level, cts_level};
  wire [CDMP_DATA_W-1:0] rd_mux =
    (haddr == CDMP_MODE_ADDR) ? {{(CDMP_DATA_W-CDMP_MODE_W){1'b0}}, mode} :
    (haddr == CDMP_OUTS_ADDR) ? {{(CDMP_DATA_W-CDMP_OUTS_W){1'b0}}, outs} :
    (haddr == CDMP_STAT_ADDR) ? {{(CDMP_DATA_W-CDMP_STAT_W){1'b0}}, status} :
    (haddr == CDMP_EVT_ADDR) ? {{(CDMP_DATA_W-CDMP_EVT_W){1'b0}}, events} :
    (haddr == CDMP_IEN_ADDR) ? {{(CDMP_DATA_W-CDMP_IEN_W){1'b0}}, irq_en} :
    {CDMP_DATA_W{1'b0}};

  // zero-wait slave; read data sampled at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_addr <= {CDMP_ADDR_W{1'b0}};
      hrdata <= {CDMP_DATA_W{1'b0}};
      hreadyout <= 1'b1;
      hresp <= CDMP_HRESP_OKAY;
    end else begin
      ph_write <= addr_phase & hwrite;
      ph_addr <= haddr;
      hrdata <= (addr_phase & ~hwrite) ? rd_mux : {CDMP_DATA_W{1'b0}};
      hreadyout <= 1'b1;
      hresp <= CDMP_HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= CDMP_MODE_RESET;
      outs <= CDMP_OUTS_RESET;
      irq_en <= CDMP_IEN_RESET;
    end else if (wr_now) begin
      if (hit_mode) begin
        mode <= hwdata[CDMP_MODE_W-1:0];
      end
      if (hit_outs) begin
        outs <= hwdata[CDMP_OUTS_W-1:0];
      end
      if (hit_ien) begin
        irq_en <= hwdata[CDMP_IEN_W-1:0];
      end
    end
  end

  // acknowledge leading edges start one dma cycle each
  wire ack1_start = ack1_level & ~ack_prev[0];
  wire ack2_start = ack2_level & ~ack_prev[1];
  wire dma_cycle1 = single_addr & ack1_start;
  wire half_rx = in_half & dma_cycle1 & rx_enabled;
  wire half_tx = in_half & dma_cycle1 & ~rx_enabled & tx_enabled;
  wire full_rx = in_full & dma_cycle1;
  wire full_tx = in_full & single_addr & ack2_start;
  wire next_rx_read = half_rx | full_rx;
  wire next_tx_load = half_tx | full_tx;
  // last transmit load marked by input
  wire next_tx_last = next_tx_load & eop_in_level;
  // final receive read or terminal count
  wire next_eop_drive = (next_rx_read & rx_fifo_last) | tx_count_terminal;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_prev <= 2'h0;
      dma_rx_read <= 1'b0;
      dma_tx_load <= 1'b0;
      dma_tx_last <= 1'b0;
      end_of_process_oe <= 1'b0;
      end_of_process_out_n <= 1'b0;
    end else begin
      ack_prev <= {ack2_level, ack1_level};
      dma_rx_read <= next_rx_read;
      dma_tx_load <= next_tx_load;
      dma_tx_last <= next_tx_last;
      // active in any dma mode setting
      end_of_process_oe <= next_eop_drive;
      end_of_process_out_n <= 1'b0;
    end
  end

  // sticky events, set wins over a write-one clear
  wire [CDMP_EVT_W-1:0] evt_set = {next_eop_drive, next_tx_last, pin_change};
  wire [CDMP_EVT_W-1:0] evt_clr = (wr_now & hit_evt) ? hwdata[CDMP_EVT_W-1:0] : {CDMP_EVT_W{1'b0}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events <= {CDMP_EVT_W{1'b0}};
      modem_irq <= 1'b0;
    end else begin
      events <= (events & ~evt_clr) | evt_set;
      modem_irq <= |(events[CDMP_IEN_W-1:0] & irq_en);
    end
  end

  // requests follow fifo state each cycle
  wire half_req = (rx_enabled & rx_fifo_not_empty) | (tx_enabled & tx_fifo_not_full);
  wire full_req = rx_enabled & rx_fifo_not_empty;
  wire req1 = in_half ? half_req : in_full ? full_req : outs[CDMP_O_GPO1];
  wire pin2_sw = mode[CDMP_M_P2_RTS] ? outs[CDMP_O_RTS] : outs[CDMP_O_GPO2];
  wire req2 = in_full ? (tx_enabled & tx_fifo_not_full) : pin2_sw;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      combined_dma_request_n <= 1'b1;
      transmit_dma_request_n <= 1'b1;
      loop_control_out_n <= 1'b1;
      loop_control_oe <= 1'b0;
      tx_allow <= 1'b1;
      rx_allow <= 1'b1;
      rx_sync_force <= 1'b0;
    end else begin
      combined_dma_request_n <= ~req1;
      transmit_dma_request_n <= ~req2;
      loop_control_oe <= loop_mode;
      loop_control_out_n <= ~outs[CDMP_O_LOOP];
      tx_allow <= ~mode[CDMP_M_CTS_EN] | loop_mode | cts_level;
      rx_allow <= ~mode[CDMP_M_DCD_EN] | ext_sync | dcd_level;
      rx_sync_force <= ext_sync & mode[CDMP_M_COP] & ~carrier_detect_in_n & ~dcd_level;
    end
  end

  // one bit time delay on sync detect
  always_comb begin
    next_sy_state = sy_state;
    case (sy_state)
      CDMP_SY_IDLE: begin
        if (rx_sync_found) begin
          next_sy_state = CDMP_SY_WAIT;
        end
      end
      CDMP_SY_WAIT: begin
        if (bit_tick) begin
          next_sy_state = CDMP_SY_HOLD;
        end
      end
      CDMP_SY_HOLD: begin
        if (bit_tick) begin
          next_sy_state = rx_sync_found ? CDMP_SY_WAIT : CDMP_SY_IDLE;
        end
      end
      default: begin
        next_sy_state = CDMP_SY_IDLE;
      end
    endcase
  end

  // held for one bit time so slow modem hardware sees it
  wire sync_pin_on = mode[CDMP_M_P3_SYNC] ? (next_sy_state == CDMP_SY_HOLD) : outs[CDMP_O_RTS];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy_state <= CDMP_SY_IDLE;
      sync_detect_out_n <= 1'b1;
    end else begin
      sy_state <= next_sy_state;
      sync_detect_out_n <= ~sync_pin_on;
    end
  end

  wire rd_lead = read_strobe & ~rd_prev;
  wire wr_lead = write_strobe & ~wr_prev;
  wire wait_on = mode[CDMP_M_WAIT];
  wire rdy_set = wait_on & ((rd_lead & ~rx_fifo_not_empty) | (wr_lead & ~tx_fifo_not_full));
  // released once the fifo can serve or the strobe ends
  wire rdy_hold = ready_wait_oe & wait_on &
                  ((read_strobe & ~rx_fifo_not_empty) | (write_strobe & ~tx_fifo_not_full));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      ready_wait_oe <= 1'b0;
      ready_wait_out_n <= 1'b0;
    end else begin
      rd_prev <= read_strobe;
      wr_prev <= write_strobe;
      ready_wait_oe <= rdy_set | rdy_hold;
      ready_wait_out_n <= 1'b0;
    end
  end

  // acknowledge pins double as general inputs via status
  // levels readable in every mode
  wire unused_ok = |{hsize, in_dma, htrans[0]};
endmodule

/* File: rtl/cdmp_pin_watch.sv */
// registered active-low pin levels with one-cycle change pulses
`timescale 1ns/1ps
module cdmp_pin_watch #(
  parameter int WIDTH = 2
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic [WIDTH-1:0] pins_n, // active-low pins
  input wire logic [WIDTH-1:0] watch, // change detection enable per pin
  output logic [WIDTH-1:0] level, // asserted level, registered
  output logic [WIDTH-1:0] change // one-cycle pulse on a level change while watch is set for that pin
);
  logic [WIDTH-1:0] prev;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      wire next_level = ~pins_n[i];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          level[i] <= 1'b0;
          prev[i] <= 1'b0;
          change[i] <= 1'b0;
        end else begin
          level[i] <= next_level;
          prev[i] <= level[i];
          change[i] <= watch[i] & (level[i] ^ prev[i]);
        end
      end
    end
  endgenerate
endmodule

/* File: rtl/cdmp_pkg.sv */
// constants shared by the channel dma and modem pin logic
package cdmp_pkg;
  localparam int CDMP_ADDR_W = 8;
  localparam int CDMP_DATA_W = 32;
  localparam logic [7:0] CDMP_MODE_ADDR = 8'h00;
  localparam logic [7:0] CDMP_OUTS_ADDR = 8'h04;
  localparam logic [7:0] CDMP_STAT_ADDR = 8'h08;
  localparam logic [7:0] CDMP_EVT_ADDR = 8'h0c;
  localparam logic [7:0] CDMP_IEN_ADDR = 8'h10;
  localparam int CDMP_M_DMA = 0;
  localparam int CDMP_M_SINGLE = 2;
  localparam int CDMP_M_CTS_EN = 3;
  localparam int CDMP_M_LOOP = 4;
  localparam int CDMP_M_DCD_EN = 5;
  localparam int CDMP_M_EXT_SYNC = 6;
  localparam int CDMP_M_P2_RTS = 7;
  localparam int CDMP_M_P3_SYNC = 8;
  localparam int CDMP_M_WAIT = 9;
  localparam int CDMP_M_COP = 10;
  localparam int CDMP_MODE_W = 11;
  localparam int CDMP_O_GPO1 = 0;
  localparam int CDMP_O_GPO2 = 1;
  localparam int CDMP_O_RTS = 2;
  localparam int CDMP_O_LOOP = 3;
  localparam int CDMP_OUTS_W = 4;
  localparam int CDMP_E_CTS = 0;
  localparam int CDMP_E_DCD = 1;
  localparam int CDMP_E_LAST_TX = 2;
  localparam int CDMP_E_EOP_OUT = 3;
  localparam int CDMP_EVT_W = 4;
  localparam int CDMP_IEN_W = 2;
  localparam int CDMP_STAT_W = 7;
  localparam logic [1:0] CDMP_DMA_NONE = 2'h0;
  localparam logic [1:0] CDMP_DMA_HALF = 2'h1;
  localparam logic [1:0] CDMP_DMA_FULL = 2'h2;
  localparam logic [CDMP_MODE_W-1:0] CDMP_MODE_RESET = 11'h000;
  localparam logic [CDMP_OUTS_W-1:0] CDMP_OUTS_RESET = 4'h0;
  localparam logic [CDMP_IEN_W-1:0] CDMP_IEN_RESET = 2'h0;
  localparam logic [1:0] CDMP_HTRANS_NONSEQ = 2'h2;
  localparam logic CDMP_HRESP_OKAY = 1'b0;
  typedef enum logic [2:0] {
    CDMP_SY_IDLE = 3'b001,
    CDMP_SY_WAIT = 3'b010,
    CDMP_SY_HOLD = 3'b100
  } cdmp_sync_type;
endpackage

/* File: tb/cdmp_chk.sv */
// port assertions for the channel dma and modem pin logic
`timescale 1ns/1ps
module cdmp_chk (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hreadyout, // bus ready
  input wire logic hresp, // bus response
  input wire logic clear_to_send_in_n, // cts pin
  input wire logic carrier_detect_in_n, // carrier pin
  input wire logic combined_dma_acknowledge_n, // ack one
  input wire logic transmit_dma_acknowledge_n, // ack two
  input wire logic end_of_process_out_n, // eop level
  input wire logic end_of_process_oe, // eop drive
  input wire logic bit_tick, // bit time
  input wire logic tx_allow, // tx gate
  input wire logic rx_sync_force, // forced sync
  input wire logic dma_rx_read, // rx read
  input wire logic dma_tx_load, // tx load
  input wire logic dma_tx_last, // last load
  input wire logic sync_detect_out_n // sync pin
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // output register adds a stage, so the tick may lie up to three edges back
  sequence s_tick_before;
    $past(bit_tick) || $past(bit_tick, 2) || $past(bit_tick, 3);
  endsequence
  sequence s_ack_seen;
    !$past(combined_dma_acknowledge_n) || !$past(transmit_dma_acknowledge_n);
  endsequence
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
  property p_eop_level; !end_of_process_out_n; endproperty
  a_eop_level: assert property (p_eop_level) else $error("eop drive level not low");
  property p_tx_gate; $fell(tx_allow) |-> $past(clear_to_send_in_n); endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx stopped with cts asserted");
  property p_force; rx_sync_force |-> !$past(carrier_detect_in_n) ##1 !rx_sync_force; endproperty
  a_force: assert property (p_force) else $error("sync forced without pin low");
  property p_rx_read; dma_rx_read |-> !$past(combined_dma_acknowledge_n) ##1 !dma_rx_read; endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx read without ack");
  property p_tx_load; dma_tx_load |-> s_ack_seen ##1 !dma_tx_load; endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx load without ack");
  property p_last; dma_tx_last |-> dma_tx_load; endproperty
  a_last: assert property (p_last) else $error("last flag without load");
  property p_eop_pulse; end_of_process_oe |=> !end_of_process_oe; endproperty
  a_eop_pulse: assert property (p_eop_pulse) else $error("eop drive longer than a cycle");
  property p_sync_out; $fell(sync_detect_out_n) |-> s_tick_before; endproperty
  a_sync_out: assert property (p_sync_out) else $error("sync pin not on bit time");
endmodule
bind cdmp_channel cdmp_chk chk_u (.*);

/* File: tb/cdmp_far_end.sv */
// dma controller and pulled-up eop wire at the channel's far side
`timescale 1ns/1ps
module cdmp_far_end (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic go1, // serve combined request
  input wire logic go2, // serve transmit request
  input wire logic last, // mark load as final
  input wire logic combined_dma_request_n, // request one
  input wire logic transmit_dma_request_n, // request two
  input wire logic end_of_process_oe, // device pulls eop
  output logic combined_dma_acknowledge_n, // ack one
  output logic transmit_dma_acknowledge_n, // ack two
  output logic end_of_process_in_n // eop wire
);
  logic [2:0] cnt;
  logic own_eop;
  logic take1;
  assign take1 = go1 && !combined_dma_request_n;
  assign end_of_process_in_n = !(end_of_process_oe || own_eop);
  // ack two cycles, then a gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 3'h0;
      combined_dma_acknowledge_n <= 1'b1;
      transmit_dma_acknowledge_n <= 1'b1;
      own_eop <= 1'b0;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h3) begin
        combined_dma_acknowledge_n <= 1'b1;
        transmit_dma_acknowledge_n <= 1'b1;
        own_eop <= 1'b0;
      end
    end else if (take1 || (go2 && !transmit_dma_request_n)) begin
      cnt <= 3'h4;
      combined_dma_acknowledge_n <= !take1;
      transmit_dma_acknowledge_n <= take1;
      own_eop <= last;
    end
  end
endmodule

/* File: tb/test_cdmp_channel.sv */
// self-checking bench for the channel dma and modem pin logic
`timescale 1ns/1ps
module test_cdmp_channel import cdmp_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, go1, go2, last;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize = 3'h2;
  logic [2:0] tk = 3'h0;
  logic [31:0] hwdata, hrdata;
  logic clear_to_send_in_n, carrier_detect_in_n, combined_dma_acknowledge_n, transmit_dma_acknowledge_n;
  logic end_of_process_in_n, rx_enabled, tx_enabled, rx_fifo_not_empty, rx_fifo_last, tx_fifo_not_full;
  logic tx_count_terminal, rx_sync_found, bit_tick, read_strobe, write_strobe, loop_control_out_n;
  logic loop_control_oe, combined_dma_request_n, transmit_dma_request_n, sync_detect_out_n;
  logic end_of_process_out_n, end_of_process_oe, ready_wait_out_n, ready_wait_oe, tx_allow, rx_allow;
  logic rx_sync_force, dma_rx_read, dma_tx_load, dma_tx_last, modem_irq;
  wire logic hready;
  int n_errors, total_checks, n_f1, n_f2, n_rd, n_ld, n_last, n_eop, n_sf, n_sd;
  // rows: mode, outs, {rx_en,tx_en,rx_ne,tx_nf}, then expected pins or transfers
  localparam logic [31:0] PT [10] = '{32'h00010001, 32'h00020002, 32'h18040002, 32'h18020003,
    32'h0010a001, 32'h00106003, 32'h00105001, 32'h0020d002, 32'h0020e001, 32'h0021c003};
  localparam logic [31:0] DT [4] = '{32'h0060f022, 32'h0060f011, 32'h00505021, 32'h0020f020};
  localparam logic [7:0] RA [5] = '{CDMP_MODE_ADDR, CDMP_OUTS_ADDR, CDMP_EVT_ADDR, CDMP_IEN_ADDR, 8'h20};
  assign hready = hreadyout;
  cdmp_channel dut_u (.*);
  cdmp_far_end far_u (.*);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    n_f1 += int'($fell(combined_dma_acknowledge_n));
    n_f2 += int'($fell(transmit_dma_acknowledge_n));
    n_rd += int'(dma_rx_read);
    n_ld += int'(dma_tx_load);
    n_last += int'(dma_tx_last);
    n_eop += int'(end_of_process_oe);
    n_sf += int'(rx_sync_force);
    n_sd += int'(!sync_detect_out_n);
    tk <= tk + 3'h1;
    bit_tick <= &tk;
  end
  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // run takes about 370 cycles
  initial begin
    #100000;
    n_errors++;
    results();
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // counters cleared off the edge so the monitor never races them
  task automatic clr();
    @(negedge hclk);
    {n_f1, n_f2, n_rd, n_ld, n_last, n_eop, n_sf, n_sd} = '0;
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= CDMP_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("hrdata", exp, hrdata);
  endtask
  task automatic pulse_dma(input logic [1:0] g, input int n);
    {go1, go2} <= g;
    cyc(n);
    {go1, go2} <= 2'b00;
    cyc(10);
  endtask
  initial begin
    {hsel, hwrite, go1, go2, last, rx_enabled, tx_enabled, rx_fifo_not_empty, rx_fifo_last} = '0;
    {tx_fifo_not_full, tx_count_terminal, rx_sync_found, read_strobe, write_strobe} = '0;
    {haddr, htrans, hwdata, hresetn, bit_tick} = '0;
    {clear_to_send_in_n, carrier_detect_in_n} = 2'b11;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (RA[i]) rd(RA[i], 32'h0);
    foreach (PT[i]) begin
      wr(CDMP_MODE_ADDR, 32'(PT[i][31:20]));
      wr(CDMP_OUTS_ADDR, 32'(PT[i][19:16]));
      {rx_enabled, tx_enabled, rx_fifo_not_empty, tx_fifo_not_full} <= PT[i][15:12];
      cyc(3);
      chk("req_pins", 32'(PT[i][1:0]), 32'({combined_dma_request_n, transmit_dma_request_n}));
    end
    foreach (DT[i]) begin
      wr(CDMP_MODE_ADDR, 32'(DT[i][31:20]));
      {rx_enabled, tx_enabled, rx_fifo_not_empty, tx_fifo_not_full} <= DT[i][15:12];
      cyc(3);
      clr();
      pulse_dma(DT[i][5:4], 20);
      chk("acks_seen", 32'h1, 32'(n_f1 + n_f2 > 0));
      chk("rx_reads", DT[i][1] ? 32'(n_f1) : 32'h0, 32'(n_rd));
      chk("tx_loads", DT[i][0] ? 32'(n_f1 + n_f2) : 32'h0, 32'(n_ld));
    end
    wr(CDMP_MODE_ADDR, 32'h006);
    rx_fifo_last <= 1'b1;
    clr();
    pulse_dma(2'b10, 1);
    chk("eop_rx", 32'h11, 32'(n_rd * 16 + n_eop));
    clr();
    last <= 1'b1;
    pulse_dma(2'b01, 1);
    chk("eop_tx", 32'h11, 32'(n_ld * 16 + n_last));
    last <= 1'b0;
    clr();
    tx_count_terminal <= 1'b1;
    cyc(1);
    tx_count_terminal <= 1'b0;
    cyc(5);
    chk("eop_tc", 32'h1, 32'(n_eop));
    rd(CDMP_EVT_ADDR, 32'hc);
    wr(CDMP_EVT_ADDR, 32'hc);
    wr(CDMP_IEN_ADDR, 32'h3);
    wr(CDMP_MODE_ADDR, 32'h028);
    cyc(3);
    chk("allow", 32'h0, 32'({tx_allow, rx_allow}));
    {clear_to_send_in_n, carrier_detect_in_n} <= 2'b00;
    cyc(6);
    chk("allow", 32'h3, 32'({tx_allow, rx_allow}));
    chk("irq", 32'h1, 32'(modem_irq));
    rd(CDMP_STAT_ADDR, 32'h63);
    rd(CDMP_EVT_ADDR, 32'h3);
    wr(CDMP_EVT_ADDR, 32'h1);
    rd(CDMP_EVT_ADDR, 32'h2);
    wr(CDMP_EVT_ADDR, 32'h2);
    cyc(3);
    chk("irq", 32'h0, 32'(modem_irq));
    wr(CDMP_IEN_ADDR, 32'h2);
    clear_to_send_in_n <= 1'b1;
    cyc(6);
    chk("irq", 32'h0, 32'(modem_irq));
    rd(CDMP_EVT_ADDR, 32'h1);
    // loop output, no cts gating in loop
    wr(CDMP_MODE_ADDR, 32'h018);
    wr(CDMP_OUTS_ADDR, 32'h8);
    cyc(3);
    chk("loop", 32'h5, 32'({loop_control_oe, loop_control_out_n, tx_allow}));
    wr(CDMP_OUTS_ADDR, 32'h0);
    cyc(3);
    chk("loop", 32'h3, 32'({loop_control_oe, loop_control_out_n}));
    carrier_detect_in_n <= 1'b1;
    wr(CDMP_MODE_ADDR, 32'h440);
    cyc(3);
    clr();
    carrier_detect_in_n <= 1'b0;
    cyc(8);
    chk("sync_force", 32'h1, 32'(n_sf));
    // sync pin low for one bit time
    wr(CDMP_MODE_ADDR, 32'h100);
    cyc(2);
    clr();
    rx_sync_found <= 1'b1;
    cyc(1);
    rx_sync_found <= 1'b0;
    cyc(30);
    chk("sync_low", 32'h8, 32'(n_sd));
    // ready on strobe when fifo cannot serve
    wr(CDMP_MODE_ADDR, 32'h200);
    rx_fifo_not_empty <= 1'b0;
    read_strobe <= 1'b1;
    cyc(3);
    chk("ready", 32'h2, 32'({ready_wait_oe, ready_wait_out_n}));
    read_strobe <= 1'b0;
    write_strobe <= 1'b1;
    cyc(3);
    chk("ready", 32'h0, 32'(ready_wait_oe));
    write_strobe <= 1'b0;
    results();
  end
endmodule
